// file: src/wwd_top.sv
// windowed watchdog: counter, window check, interval interrupt and reset request
// Notes on behaviour
// - a missed service before overflow, or with autostart set a failed one, raises the internal reset.
// - with the interval option set an interrupt fires at 75% of overflow plus half a tick.
// - span code 01/10/11 opens the last 50/75/100% of the period; 00 is not to be used.
// - with autostart set counting begins at reset release, otherwise it stays stopped until a key write that is the first write or lands in the open window.
// - the period code 0..7 selects 2^6,7,8,9,11,13,14,16 watchdog ticks.
// - in low-power states the counter stops unless the low-power option bit is set.
// - writing the key to the kick register in the open window clears and restarts the counter.
// - the first kick write after reset release is not window checked.
// - with autostart set a kick write in the closed window raises the internal reset.
// - with autostart set a kick write of any non-key value raises the internal reset.
// - with autostart set a single-bit kick write raises the internal reset.
// - the kick register reads 1a after reset with autostart set, else 9a.
// - configuration comes from the option byte sampled on the first edge after reset release and is fixed after.
`timescale 1ns/10ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       SRST,
  input  wire logic [7:0] OPTION_BYTE,
  input  wire logic       WDT_CLK_IN,
  input  wire logic       LOW_POWER,
  input  wire logic       KICK_WR,
  input  wire logic       KICK_BIT_WR,
  input  wire logic [7:0] KICK_WDATA,
  output logic      [7:0] KICK_RDATA,
  output logic            INTERVAL_IRQ,
  output logic            WDT_RESET_REQ
);
  import wwd_pkg::*;

  // option byte, caught on the first edge after reset release
  logic       cfg_valid_q;
  logic [7:0] cfg_q;
  logic       interval_irq_use, counter_autostart, count_in_low_power;
  logic [1:0] open_span_field;
  logic [2:0] overflow_period_select;
  assign interval_irq_use       = cfg_q[WWD_IRQ_USE_POS];
  assign open_span_field        = cfg_q[WWD_SPAN_POS +: 2];
  assign counter_autostart      = cfg_q[WWD_AUTOSTART_POS];
  assign overflow_period_select = cfg_q[WWD_PERIOD_POS +: 3];
  assign count_in_low_power     = cfg_q[WWD_LOWPWR_POS];

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      cfg_valid_q <= 1'b0;
    else
      cfg_valid_q <= 1'b1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      cfg_q <= 8'h00;
    else if (!cfg_valid_q)
      cfg_q <= OPTION_BYTE;
  end

  // watchdog clock from a pin: three stages, an edge counts when stages two and three agree
  logic [2:0] wclk_sync_q;
  logic       wclk_lvl_q;
  logic       half_tick;
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      wclk_sync_q <= 3'h0;
    else
      wclk_sync_q <= {wclk_sync_q[1:0], WDT_CLK_IN};
  end
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      wclk_lvl_q <= 1'b0;
    else if (wclk_sync_q[1] == wclk_sync_q[2])
      wclk_lvl_q <= wclk_sync_q[2];
  end
  // both edges count: the counter runs in half watchdog ticks
  assign half_tick = (wclk_sync_q[1] == wclk_sync_q[2]) && (wclk_sync_q[2] != wclk_lvl_q);

  // overflow length in half ticks
  logic [4:0]           period_exp;
  logic [WWD_CNT_W-1:0] ovf_half;
  logic [WWD_CNT_W-1:0] irq_half;
  logic [WWD_CNT_W-1:0] open_start;
  always_comb
  begin
    case (overflow_period_select)
      3'h0:    period_exp = 5'd6;
      3'h1:    period_exp = 5'd7;
      3'h2:    period_exp = 5'd8;
      3'h3:    period_exp = 5'd9;
      3'h4:    period_exp = 5'd11;
      3'h5:    period_exp = 5'd13;
      3'h6:    period_exp = 5'd14;
      default: period_exp = 5'd16;
    endcase
  end
  assign ovf_half = WWD_CNT_W'(1) << (period_exp + 5'd1);
  // 75% of the period plus half a tick
  assign irq_half = (ovf_half - (ovf_half >> 2)) + WWD_CNT_W'(1);
  always_comb
  begin
    case (open_span_field)
      WWD_SPAN_50:  open_start = ovf_half >> 1;
      WWD_SPAN_75:  open_start = ovf_half >> 2;
      WWD_SPAN_100: open_start = WWD_CNT_RST;
      default:      open_start = ovf_half >> 1;
    endcase
  end

  // counter and sequencing
  wwd_state_t           state_q, state_d;
  logic [WWD_CNT_W-1:0] cnt_q, cnt_d;
  logic                 first_done_q;
  logic                 running, advance, in_open, key_ok, bad_write, good_kick, overflow;
  assign running   = (state_q == WWD_RUN);
  assign advance   = running && half_tick && (!LOW_POWER || count_in_low_power);
  assign in_open   = (cnt_q >= open_start) || !first_done_q;
  assign key_ok    = (KICK_WDATA == WWD_KEY);
  assign good_kick = KICK_WR && !KICK_BIT_WR && key_ok && in_open;
  // only an autostart watchdog punishes bad writes
  assign bad_write = counter_autostart && (KICK_BIT_WR
                     || (KICK_WR && !key_ok)
                     || (KICK_WR && !in_open));
  assign overflow  = advance && (cnt_q == ovf_half - WWD_CNT_W'(1));

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      WWD_IDLE:
      begin
        if (cfg_valid_q && counter_autostart)
          state_d = WWD_RUN;
        else if (cfg_valid_q && good_kick)
        begin
          state_d = WWD_RUN;
          cnt_d   = WWD_CNT_RST;
        end
      end
      WWD_RUN:
      begin
        if (bad_write || overflow)
          state_d = WWD_FIRE;
        else if (good_kick)
          cnt_d = WWD_CNT_RST;
        else if (advance)
          cnt_d = cnt_q + WWD_CNT_W'(1);
      end
      WWD_FIRE:
        state_d = WWD_FIRE;
      default:
        state_d = WWD_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state_q <= WWD_IDLE;
      cnt_q   <= WWD_CNT_RST;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      first_done_q <= 1'b0;
    else if (KICK_WR && cfg_valid_q)
      first_done_q <= 1'b1;
  end

  // outputs; reset request holds until the system reset comes back
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      INTERVAL_IRQ  <= 1'b0;
      WDT_RESET_REQ <= 1'b0;
      KICK_RDATA    <= WWD_KICK_RST_MANUAL;
    end
    else
    begin
      INTERVAL_IRQ  <= interval_irq_use && advance && (cnt_q == irq_half - WWD_CNT_W'(1));
      WDT_RESET_REQ <= (state_d == WWD_FIRE);
      KICK_RDATA    <= counter_autostart ? WWD_KICK_RST_AUTO : WWD_KICK_RST_MANUAL;
    end
  end
endmodule
`default_nettype wire

// file: src/wwd_pkg.sv
// package: constants and types for the windowed watchdog
package wwd_pkg;
  localparam logic [19:0] WWD_OPTION_OFS      = 20'h000c0;
  localparam logic [19:0] WWD_KICK_OFS        = 20'hfffab;
  localparam logic [7:0]  WWD_KEY             = 8'hac;
  localparam logic [7:0]  WWD_KICK_RST_AUTO   = 8'h1a;
  localparam logic [7:0]  WWD_KICK_RST_MANUAL = 8'h9a;
  // option byte field positions
  localparam int WWD_IRQ_USE_POS   = 7;
  localparam int WWD_SPAN_POS      = 5;
  localparam int WWD_AUTOSTART_POS = 4;
  localparam int WWD_PERIOD_POS    = 1;
  localparam int WWD_LOWPWR_POS    = 0;
  localparam logic [1:0] WWD_SPAN_50  = 2'h1;
  localparam logic [1:0] WWD_SPAN_75  = 2'h2;
  localparam logic [1:0] WWD_SPAN_100 = 2'h3;
  // counter width covers 2^16 half-periods doubled (half-tick resolution)
  localparam int WWD_CNT_W = 18;
  localparam logic [WWD_CNT_W-1:0] WWD_CNT_RST = 18'h00000;
  localparam int WWD_RST_PULSE_CYCLES = 1;
  typedef enum logic [1:0] {WWD_IDLE, WWD_RUN, WWD_FIRE} wwd_state_t;
endpackage

// file: verification/wwd_properties.sv
// checker: port-level assertions for the windowed watchdog
`timescale 1ns/10ps
`default_nettype none
module wwd_properties
  import wwd_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       SRST,
  input wire logic [7:0] OPTION_BYTE,
  input wire logic       KICK_WR,
  input wire logic       KICK_BIT_WR,
  input wire logic [7:0] KICK_WDATA,
  input wire logic [7:0] KICK_RDATA,
  input wire logic       INTERVAL_IRQ,
  input wire logic       WDT_RESET_REQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // autostart is only visible through the kick readback value
  wire logic auto_on = KICK_RDATA == WWD_KICK_RST_AUTO;
  req_hold_a: assert property (WDT_RESET_REQ |=> WDT_RESET_REQ)
    else $error("reset request dropped");
  rst_quiet_a: assert property ($fell(SRST) |-> !WDT_RESET_REQ && !INTERVAL_IRQ)
    else $error("outputs active in reset");
  rd_reset_a: assert property ($fell(SRST) |-> KICK_RDATA == WWD_KICK_RST_MANUAL)
    else $error("readback wrong in reset");
  rd_value_a: assert property (auto_on || KICK_RDATA == WWD_KICK_RST_MANUAL)
    else $error("readback value illegal");
  irq_pulse_a: assert property (INTERVAL_IRQ |=> !INTERVAL_IRQ)
    else $error("interval pulse too long");
  irq_opt_a: assert property (INTERVAL_IRQ |-> OPTION_BYTE[WWD_IRQ_USE_POS])
    else $error("interval pulse while unused");
  bad_key_a: assert property (KICK_WR && KICK_WDATA != WWD_KEY && auto_on |-> ##2 WDT_RESET_REQ)
    else $error("bad key not fired");
  bit_wr_a: assert property (KICK_BIT_WR && auto_on |-> ##2 WDT_RESET_REQ)
    else $error("bit write not fired");
  cover property ($rose(WDT_RESET_REQ));
  cover property (INTERVAL_IRQ);
  cover property (KICK_WR && KICK_WDATA == WWD_KEY);
endmodule
bind wwd_top wwd_properties u_chk (.*);
`default_nettype wire

// file: verification/windowed_watchdog_timer_tb.sv
// testbench: kick, window, option and timing checks of the watchdog
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
  begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %0h seen %0h", n, e, g); end end
module windowed_watchdog_timer_tb;
  import wwd_pkg::*;
  typedef struct {logic [7:0] o; logic b; logic [7:0] d1; logic two; logic [7:0] d2; logic e;} wwd_row_t;
  logic       clk = 0, srst = 1, lp = 0, kwr = 0, kbit = 0, irq, req;
  logic [7:0] opt = 0, wdat = 0, rdat;
  logic [2:0] div = 0;
  int         miscompares = 0, checks = 0, i, t, irq_at, rst_at;
  wwd_row_t   rows [8] = '{'{8'h30, 0, 8'h55, 0, 0, 1}, '{8'h30, 1, 0, 0, 0, 1},
    '{8'h30, 0, 8'hac, 0, 0, 0}, '{8'h30, 0, 8'hac, 1, 8'hac, 1}, '{8'h50, 0, 8'hac, 1, 8'hac, 1},
    '{8'h70, 0, 8'hac, 1, 8'hac, 0}, '{8'h20, 0, 8'h55, 1, 8'hac, 0}, '{8'h20, 0, 8'hac, 1, 0, 0}};
  wwd_top dut (.REF_CLK(clk), .SRST(srst), .OPTION_BYTE(opt), .WDT_CLK_IN(div[2]), .LOW_POWER(lp),
    .KICK_WR(kwr), .KICK_BIT_WR(kbit), .KICK_WDATA(wdat), .KICK_RDATA(rdat),
    .INTERVAL_IRQ(irq), .WDT_RESET_REQ(req));
  initial forever #5 clk = ~clk;
  // watchdog tick: one half tick every 4 system cycles
  always @(posedge clk) div <= div + 3'h1;
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic boot(input logic [7:0] o);
    @(posedge clk);
    srst <= 1;
    opt <= o;
    repeat (3) @(posedge clk);
    srst <= 0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("rdata", o[4] ? WWD_KICK_RST_AUTO : WWD_KICK_RST_MANUAL, rdat)
  endtask
  task automatic kick(input logic b, input logic [7:0] d);
    @(posedge clk);
    kwr <= !b;
    kbit <= b;
    wdat <= d;
  endtask
  initial
  begin
    #60000;
    miscompares++;
    finish_test;
  end
  initial
  begin
    for (i = 0; i < 8; i++)
    begin
      boot(rows[i].o);
      kick(rows[i].b, rows[i].d1);
      if (rows[i].two)
        kick(0, rows[i].d2);
      @(posedge clk);
      kwr <= 0;
      kbit <= 0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("reset_req", rows[i].e, req)
      $display("row %0d done", i);
    end
    // low power held throughout: only the run-in-low-power option lets it count;
    // run 2 has the interval option off, run 3 has autostart off and must stay stopped
    for (i = 0; i < 4; i++)
    begin
      lp <= 1;
      boot(i == 0 ? 8'hf0 : i == 1 ? 8'hf1 : i == 2 ? 8'h71 : 8'he1);
      irq_at = 0;
      rst_at = 0;
      for (t = 1; t < 700; t++)
      begin
        @(posedge clk);
        #1;
        if (irq === 1'b1 && irq_at == 0) irq_at = t;
        if (req === 1'b1 && rst_at == 0) rst_at = t;
      end
      `CHK("irq_time", i == 1, irq_at >= 380 && irq_at <= 400)
      `CHK("ovf_time", i == 1 || i == 2, rst_at >= 500 && rst_at <= 525)
      `CHK("lp_stop", i == 0 || i == 3, rst_at == 0)
      `CHK("irq_none", i == 1, irq_at != 0)
      `CHK("auto_off", i == 3, rdat == WWD_KICK_RST_MANUAL)
      $display("timing %0d done", i);
    end
    finish_test;
  end
endmodule
`default_nettype wire
